// [common/aar_map.svh]
// field positions, opcodes, reset values and sizes of the and/add execution logic
`ifndef AAR_MAP_SVH
`define AAR_MAP_SVH

`define AAR_INSTR_W       14
`define AAR_DATA_W        8
`define AAR_IDX_W         7
`define AAR_FILE_DEPTH    128
`define AAR_OPC_HI        13
`define AAR_OPC_LO        8
`define AAR_DST_BIT       7
`define AAR_IDX_HI        6
`define AAR_IDX_LO        0
`define AAR_OPC_AND       6'h05
`define AAR_OPC_ADD       6'h07
`define AAR_DEST_ACC      1'b0
`define AAR_DEST_FILE     1'b1
`define AAR_ACC_RST       8'h00
`define AAR_RES_ZERO      8'h00
`define AAR_NIB_W         4
`define AAR_NIB_CARRY_BIT 4
`define AAR_CARRY_BIT     8
`define AAR_IDX_ZERO      7'h00

`endif

// [common/aar_pkg.sv]
// types shared by the and/add execution logic
package aar_pkg;

  typedef enum logic [1:0]
  {
    AAR_OP_NONE = 2'b00,
    AAR_OP_AND  = 2'b01,
    AAR_OP_ADD  = 2'b10
  } aar_op_t;

  typedef struct packed
  {
    aar_op_t    op;
    logic       dest;
    logic [6:0] idx;
  } aar_exec_t;

  typedef struct packed
  {
    logic carry;
    logic nibble;
    logic zero;
  } aar_flags_t;

endpackage

// [core/aar_file_mem.sv]
// data register file: 128 bytes, registered read, write-first on same index
`timescale 1ns/100ps
`include "aar_map.svh"

module aar_file_mem
(
  input  wire logic                    i_core_clk,
  input  wire logic [`AAR_IDX_W-1:0]   i_rd_idx,
  input  wire logic                    i_wr_en,
  input  wire logic [`AAR_IDX_W-1:0]   i_wr_idx,
  input  wire logic [`AAR_DATA_W-1:0]  i_wr_data,
  output logic      [`AAR_DATA_W-1:0]  o_rd_data
);

  logic [`AAR_DATA_W-1:0] mem_q [`AAR_FILE_DEPTH];

  always_ff @(posedge i_core_clk)
  begin
    if (i_wr_en)
    begin
      mem_q[i_wr_idx] <= i_wr_data;
    end
  end

  // a write to the index being read is forwarded
  always_ff @(posedge i_core_clk)
  begin
    if (i_wr_en && (i_wr_idx == i_rd_idx))
    begin
      o_rd_data <= i_wr_data;
    end
    else
    begin
      o_rd_data <= mem_q[i_rd_idx];
    end
  end

endmodule

// [core/aar_exec.sv]
// execution logic for the and/add file register instructions
//
// Notes on behaviour
// - and: acc AND file, only zero flag
// - dest 0 to accumulator, 1 to file
// - and opcode 000101, dest, seven-bit index
// - add: sum, carry, nibble, zero; opcode 000111
// - index spans all 128 file locations
// - one word, one instruction per cycle
`timescale 1ns/100ps
`include "aar_map.svh"

module aar_exec
  import aar_pkg::*;
(
  input  wire logic                    i_core_clk,
  input  wire logic                    i_reset,
  input  wire logic                    i_instr_valid,
  input  wire logic [`AAR_INSTR_W-1:0] i_instr_word,
  input  wire logic                    i_file_wr_en,
  input  wire logic [`AAR_IDX_W-1:0]   i_file_wr_idx,
  input  wire logic [`AAR_DATA_W-1:0]  i_file_wr_data,
  output logic                         o_done,
  output logic      [`AAR_DATA_W-1:0]  o_result,
  output logic      [`AAR_DATA_W-1:0]  o_acc,
  output aar_flags_t                   o_flags
);

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  aar_exec_t              dec_d;
  aar_exec_t              exec_q;
  logic [`AAR_DATA_W-1:0] acc_q;
  aar_flags_t             flags_q;
  logic [`AAR_DATA_W-1:0] result_q;
  logic                   done_q;

  always_comb
  begin
    dec_d.op   = AAR_OP_NONE;
    dec_d.dest = i_instr_word[`AAR_DST_BIT];
    dec_d.idx  = i_instr_word[`AAR_IDX_HI:`AAR_IDX_LO];
    if (i_instr_valid)
    begin
      if (i_instr_word[`AAR_OPC_HI:`AAR_OPC_LO] == `AAR_OPC_AND)
      begin
        dec_d.op = AAR_OP_AND;
      end
      else if (i_instr_word[`AAR_OPC_HI:`AAR_OPC_LO] == `AAR_OPC_ADD)
      begin
        dec_d.op = AAR_OP_ADD;
      end
    end
  end

  always_ff @(posedge i_core_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      exec_q <= '{op: AAR_OP_NONE, dest: `AAR_DEST_ACC, idx: `AAR_IDX_ZERO};
    end
    else
    begin
      exec_q <= dec_d;
    end
  end

  // ----------------------------------------------------------------
  // file register access
  // ----------------------------------------------------------------
  logic [`AAR_DATA_W-1:0] file_rd;
  logic [`AAR_DATA_W-1:0] res_d;
  logic                   exec_valid;
  logic                   exec_wr;
  logic                   mem_we;
  logic [`AAR_IDX_W-1:0]  mem_widx;
  logic [`AAR_DATA_W-1:0] mem_wdata;

  assign exec_valid = (exec_q.op != AAR_OP_NONE);
  assign exec_wr    = exec_valid && (exec_q.dest == `AAR_DEST_FILE);
  // write-back from an instruction beats the outside write port
  assign mem_we     = exec_wr || i_file_wr_en;
  assign mem_widx   = exec_wr ? exec_q.idx : i_file_wr_idx;
  assign mem_wdata  = exec_wr ? res_d : i_file_wr_data;

  aar_file_mem u_file
  (
    .i_core_clk (i_core_clk),
    .i_rd_idx   (dec_d.idx),
    .i_wr_en    (mem_we),
    .i_wr_idx   (mem_widx),
    .i_wr_data  (mem_wdata),
    .o_rd_data  (file_rd)
  );

  // ----------------------------------------------------------------
  // arithmetic
  // ----------------------------------------------------------------
  logic [`AAR_DATA_W:0]  sum9;
  logic [`AAR_NIB_W:0]   nib5;
  logic                  res_zero;

  assign sum9     = {1'b0, acc_q} + {1'b0, file_rd};
  assign nib5     = {1'b0, acc_q[`AAR_NIB_W-1:0]} + {1'b0, file_rd[`AAR_NIB_W-1:0]};
  assign res_d    = (exec_q.op == AAR_OP_AND) ? (acc_q & file_rd)
                                              : sum9[`AAR_DATA_W-1:0];
  assign res_zero = (res_d == `AAR_RES_ZERO);

  // ----------------------------------------------------------------
  // accumulator, flags, result
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      acc_q <= `AAR_ACC_RST;
    end
    else if (exec_valid && (exec_q.dest == `AAR_DEST_ACC))
    begin
      acc_q <= res_d;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      flags_q <= '0;
    end
    else
    begin
      if (exec_valid)
      begin
        flags_q.zero <= res_zero;
      end
      if (exec_q.op == AAR_OP_ADD)
      begin
        flags_q.carry  <= sum9[`AAR_CARRY_BIT];
        flags_q.nibble <= nib5[`AAR_NIB_CARRY_BIT];
      end
    end
  end

  always_ff @(posedge i_core_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      result_q <= `AAR_RES_ZERO;
      done_q   <= 1'b0;
    end
    else
    begin
      done_q <= exec_valid;
      if (exec_valid)
      begin
        result_q <= res_d;
      end
    end
  end

  assign o_done   = done_q;
  assign o_result = result_q;
  assign o_acc    = acc_q;
  assign o_flags  = flags_q;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_reset);

  logic [`AAR_DATA_W-1:0] and_val;
  logic                   carry_val;
  logic                   nib_val;
  assign and_val   = acc_q & file_rd;
  assign carry_val = sum9[`AAR_CARRY_BIT];
  assign nib_val   = nib5[`AAR_NIB_CARRY_BIT];

  a_and_result: assert property (
    exec_q.op == AAR_OP_AND |=> o_result == $past(and_val)
      && $stable(o_flags.carry) && $stable(o_flags.nibble))
    else $error("and result or untouched flags wrong");

  a_dest_acc: assert property (
    exec_valid && exec_q.dest == `AAR_DEST_ACC |=> o_acc == $past(res_d))
    else $error("accumulator not written");

  a_dest_file: assert property (
    exec_valid && exec_q.dest == `AAR_DEST_FILE
      |-> mem_we && mem_widx == exec_q.idx && mem_wdata == res_d ##1 $stable(o_acc))
    else $error("file write-back wrong");

  a_decode_and: assert property (
    i_instr_valid && i_instr_word[`AAR_OPC_HI:`AAR_OPC_LO] == `AAR_OPC_AND
      |=> exec_q.op == AAR_OP_AND && exec_q.dest == $past(i_instr_word[`AAR_DST_BIT]))
    else $error("and opcode not decoded");

  a_add_flags: assert property (
    exec_q.op == AAR_OP_ADD
      |=> o_flags.carry == $past(carry_val) && o_flags.nibble == $past(nib_val))
    else $error("add carries wrong");

  a_index_range: assert property (
    i_instr_valid && dec_d.op != AAR_OP_NONE
      |=> exec_q.idx == $past(i_instr_word[`AAR_IDX_HI:`AAR_IDX_LO]))
    else $error("index field lost");

  a_one_cycle: assert property (
    dec_d.op != AAR_OP_NONE |-> ##2 o_done)
    else $error("instruction not done in time");

  a_no_spurious: assert property (
    dec_d.op == AAR_OP_NONE |-> ##2 !o_done)
    else $error("done without instruction");

  a_zero_flag: assert property (
    o_done |-> o_flags.zero == (o_result == `AAR_RES_ZERO))
    else $error("zero flag mismatch");

  a_idle_hold: assert property (
    !exec_valid |=> $stable(o_result) && $stable(o_acc) && $stable(o_flags))
    else $error("outputs changed without instruction");

  c_and_acc: cover property (exec_q.op == AAR_OP_AND && exec_q.dest == `AAR_DEST_ACC);
  c_add_file: cover property (exec_q.op == AAR_OP_ADD && exec_q.dest == `AAR_DEST_FILE);
  c_add_carry: cover property (exec_q.op == AAR_OP_ADD && carry_val && nib_val);
  c_back_to_back: cover property (exec_valid ##1 exec_valid);
  c_same_edge_poke: cover property (i_file_wr_en && dec_d.op != AAR_OP_NONE
    && i_file_wr_idx == dec_d.idx);

endmodule

// [tb/aar_far.sv]
// far-side model: instruction word source and outside file writer
`timescale 1ns/100ps
`include "aar_map.svh"
module aar_far
(
  input  wire logic                    i_core_clk,
  output logic                         o_valid,
  output logic      [`AAR_INSTR_W-1:0] o_word,
  output logic                         o_wr_en,
  output logic      [`AAR_IDX_W-1:0]   o_wr_idx,
  output logic      [`AAR_DATA_W-1:0]  o_wr_data
);
  initial
  begin
    o_valid = 1'b0;
    o_word = 14'h0000;
    o_wr_en = 1'b0;
    o_wr_idx = 7'h00;
    o_wr_data = 8'h00;
  end
  // one word held for one edge, then scrambled
  task automatic issue(input logic [`AAR_INSTR_W-1:0] w);
    @(posedge i_core_clk);
    o_valid <= 1'b1;
    o_word <= w;
    @(posedge i_core_clk);
    o_valid <= 1'b0;
    o_word <= ~w;
  endtask
  // two words on consecutive edges, then scrambled
  task automatic issue_pair(input logic [`AAR_INSTR_W-1:0] w1,
                            input logic [`AAR_INSTR_W-1:0] w2);
    @(posedge i_core_clk);
    o_valid <= 1'b1;
    o_word <= w1;
    @(posedge i_core_clk);
    o_word <= w2;
    @(posedge i_core_clk);
    o_valid <= 1'b0;
    o_word <= ~w2;
  endtask
  // outside write of one file byte
  task automatic poke(input logic [`AAR_IDX_W-1:0] a, input logic [`AAR_DATA_W-1:0] d);
    @(posedge i_core_clk);
    o_wr_en <= 1'b1;
    o_wr_idx <= a;
    o_wr_data <= d;
    @(posedge i_core_clk);
    o_wr_en <= 1'b0;
    o_wr_idx <= ~a;
    o_wr_data <= ~d;
  endtask
endmodule

// [tb/tb.sv]
// self-checking bench for the and/add execution logic
`timescale 1ns/100ps
module tb;
  import aar_pkg::*;
  logic        i_core_clk;
  logic        i_reset;
  logic        valid;
  logic [13:0] word;
  logic        wr_en;
  logic [6:0]  wr_idx;
  logic [7:0]  wr_data;
  logic        o_done;
  logic [7:0]  o_result;
  logic [7:0]  o_acc;
  aar_flags_t  o_flags;
  int          error_cnt;
  int          samples_checked;
  int          cyc;

  aar_far far (.i_core_clk(i_core_clk), .o_valid(valid), .o_word(word), .o_wr_en(wr_en),
               .o_wr_idx(wr_idx), .o_wr_data(wr_data));
  aar_exec uut (.i_core_clk(i_core_clk), .i_reset(i_reset), .i_instr_valid(valid),
                .i_instr_word(word), .i_file_wr_en(wr_en), .i_file_wr_idx(wr_idx),
                .i_file_wr_data(wr_data), .o_done(o_done), .o_result(o_result),
                .o_acc(o_acc), .o_flags(o_flags));

  initial
  begin
    i_core_clk = 1'b0;
    forever #50 i_core_clk = ~i_core_clk;
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // outputs of one finished instruction while done stands
  task automatic look(input logic [7:0] r, a, input logic [2:0] f);
    chk({7'h00, o_done}, 8'h01);
    chk(o_result, r);
    chk(o_acc, a);
    chk({5'h00, o_flags}, {5'h00, f});
  endtask

  // one instruction: done two edges later for one cycle, then outputs
  task automatic run(input logic [13:0] w, input logic [7:0] r, a, input logic [2:0] f);
    far.issue(w);
    @(posedge i_core_clk);
    #1;
    look(r, a, f);
    @(posedge i_core_clk);
    #1;
    chk({7'h00, o_done}, 8'h00);
  endtask

  task automatic t_add();
    run(14'h0702, 8'h17, 8'h17, 3'b000);
    run(14'h0701, 8'hD9, 8'hD9, 3'b000);
    run(14'h077F, 8'hD8, 8'hD8, 3'b110);
    $display("add test done");
  endtask

  task automatic t_and();
    run(14'h0581, 8'hC0, 8'hD8, 3'b110);
    run(14'h0500, 8'h00, 8'h00, 3'b111);
    run(14'h0701, 8'hC0, 8'hC0, 3'b000);
    $display("and test done");
  endtask

  task automatic t_range();
    run(14'h07FF, 8'hBF, 8'hC0, 3'b100);
    run(14'h077F, 8'h7F, 8'h7F, 3'b100);
    $display("range test done");
  endtask

  task automatic t_bad();
    far.issue(14'h0601);
    repeat (3)
    begin
      @(posedge i_core_clk);
      #1;
      chk({7'h00, o_done}, 8'h00);
    end
    chk(o_acc, 8'h7F);
    $display("ignore test done");
  endtask

  // add to file then and reading it on the next edge
  task automatic t_b2b();
    far.issue_pair(14'h0782, 14'h0502);
    #1;
    look(8'h96, 8'h7F, 3'b010);
    @(posedge i_core_clk);
    #1;
    look(8'h16, 8'h16, 3'b010);
    @(posedge i_core_clk);
    #1;
    chk({7'h00, o_done}, 8'h00);
    $display("back to back test done");
  endtask

  // outside write on the edge that takes an add of that index
  task automatic t_fwd();
    fork
      far.poke(7'h00, 8'hEA);
      far.issue(14'h0700);
    join
    @(posedge i_core_clk);
    #1;
    look(8'h00, 8'h00, 3'b111);
    @(posedge i_core_clk);
    #1;
    chk({7'h00, o_done}, 8'h00);
    $display("same edge write test done");
  endtask

  always @(posedge i_core_clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      error_cnt++;
      give_verdict();
    end
  end

  initial
  begin
    error_cnt = 0;
    samples_checked = 0;
    cyc = 0;
    i_reset = 1'b1;
    repeat (12) @(posedge i_core_clk);
    i_reset <= 1'b0;
    #1;
    chk(o_acc, 8'h00);
    chk(o_result, 8'h00);
    chk({7'h00, o_done}, 8'h00);
    chk({5'h00, o_flags}, 8'h00);
    far.poke(7'h02, 8'h17);
    far.poke(7'h01, 8'hC2);
    far.poke(7'h7F, 8'hFF);
    far.poke(7'h00, 8'h00);
    t_add();
    t_and();
    t_range();
    t_bad();
    t_b2b();
    t_fwd();
    give_verdict();
  end
endmodule
